// >>> dv/eac_testbench.sv
// self-checking bench of the energy input select and line-cycle block
// assumes reads answer one cycle after the strobe, DW of 12
`timescale 1ns/1ns
module testbench;
  logic               ref_clk_i = 1'b0;
  logic               sys_rst_i = 1'b1;
  logic [15:0]        reg_addr_i = 16'h0;
  logic [31:0]        reg_wdata_i = 32'h0;
  logic               reg_wr_i = 1'b0;
  logic               reg_rd_i = 1'b0;
  logic               sample_i = 1'b0;
  logic [2:0]         zx = 3'h0;
  logic signed [11:0] s [0:22];
  wire  [31:0]        reg_rdata_o;
  wire  [1:0]         cs_o;
  wire                lp_o;
  wire  [11:0]        bv_o;
  int                 fail_count = 0;
  int                 check_count = 0;
  int                 seed = 32'h67194719;
  int                 acc [0:11];
  int                 lsum [0:11];
  int                 rm [0:22];
  int                 cs = 0;
  int                 mode = 8'h78;
  int                 np = 0;
  logic [31:0]        d;
  // ============================================================
  // design
  eac_top u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .sample_i(sample_i), .va_i(s[0]), .vb_i(s[1]), .vc_i(s[2]),
    .ia_i(s[3]), .ib_i(s[4]), .ic_i(s[5]), .ia_q_i(s[6]), .ib_q_i(s[7]),
    .ic_q_i(s[8]), .va_f_i(s[9]), .vb_f_i(s[10]), .vc_f_i(s[11]),
    .ia_f_i(s[12]), .ib_f_i(s[13]), .ic_f_i(s[14]), .va_rms_i(s[15]),
    .vb_rms_i(s[16]), .vc_rms_i(s[17]), .vac_rms_i(s[18]),
    .vsum_rms_i(s[19]), .ia_rms_i(s[20]), .ib_rms_i(s[21]),
    .ic_rms_i(s[22]), .zx_a_i(zx[0]), .zx_b_i(zx[1]), .zx_c_i(zx[2]),
    .connection_select_o(cs_o), .line_period_o(lp_o),
    .phase_b_voltage_rms_o(bv_o));
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
    if (lp_o === 1'b1)
      np = np + 1;
  // ============================================================
  // tasks
  function int grp(input int i);
    return i < 6 ? 0 : i < 9 ? 1 : 2;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [15:0] a, input int v);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
    if (a == 16'hE702)
      mode = v;
    if (a == 16'hE618)
      cs = v;
  endtask
  task rd(input logic [15:0] a);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task rdall;
    for (int i = 0; i < 12; i++)
    begin
      rd(16'hE400 + 16'(i));
      chk($sformatf("energy%0d", i), acc[i], d);
      if (mode[6])
        acc[i] = 0;
    end
  endtask
  task smp;
    logic signed [12:0] vb;
    logic signed [12:0] vf;
    int                 p [0:11];
    int                 rb;
    @(posedge ref_clk_i);
    sample_i <= 1'b1;
    foreach (s[i]) s[i] <= 12'($random(seed));
    @(posedge ref_clk_i);
    sample_i <= 1'b0;
    #1;
    foreach (s[i]) rm[i] = s[i][11:0];
    vb = cs == 0 ? s[1] : cs == 1 ? s[0] - s[2] : cs == 2 ? -s[0] - s[2]
      : -s[0];
    vf = cs == 0 ? s[10] : cs == 1 ? s[9] - s[11] : cs == 2 ? -s[9] - s[11]
      : -s[9];
    rb = cs == 0 ? rm[16] : cs == 1 ? rm[18] : cs == 2 ? rm[19] : rm[15];
    p = '{s[0] * s[3], vb * s[4], s[2] * s[5], s[9] * s[12], vf * s[13],
      s[11] * s[14], s[0] * s[6], vb * s[7], s[2] * s[8], rm[15] * rm[20],
      rb * rm[21], rm[17] * rm[22]};
    for (int i = 0; i < 12; i++)
      if (mode[grp(i)])
        lsum[i] += p[i];
      else
        acc[i] += p[i];
    chk("bv_rms", rb, bv_o);
  endtask
  task zxp(input logic [2:0] z, input int n, input int e);
    np = 0;
    repeat (n)
    begin
      @(posedge ref_clk_i);
      zx <= z;
      @(posedge ref_clk_i);
      zx <= 3'h0;
    end
    repeat (2) @(posedge ref_clk_i);
    chk("periods", e, np);
    for (int i = 0; i < 12; i++)
      if (e > 0 && mode[grp(i)])
      begin
        acc[i] = lsum[i];
        lsum[i] = 0;
      end
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ============================================================
  // sequence
  initial
  begin
    foreach (s[i]) s[i] = 12'h0;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(16'hE702);
    chk("mode", 32'h78, d);
    rd(16'hE618);
    chk("consel", 32'h0, d);
    rd(16'hE61C);
    chk("lcount", 32'h64, d);
    rd(16'hE7FE);
    chk("unmapped", 32'h0, d);
    wr(16'hE702, 32'hFF);
    rd(16'hE702);
    chk("mode", 32'h7F, d);
    wr(16'hE702, 32'h78);
    for (int c = 0; c < 4; c++)
    begin
      wr(16'hE618, c);
      chk("consel", c, cs_o);
      smp;
      rdall;
    end
    wr(16'hE702, 32'h38);
    smp;
    rdall;
    rdall;
    wr(16'hE702, 32'h78);
    rdall;
    wr(16'hE61C, 32'h4);
    rd(16'hE61C);
    chk("lcount", 32'h4, d);
    wr(16'hE702, 32'h0F);
    smp;
    smp;
    rdall;
    zxp(3'b110, 4, 0);
    zxp(3'b001, 4, 1);
    rdall;
    wr(16'hE702, 32'h3A);
    smp;
    zxp(3'b111, 1, 0);
    rd(16'hE620);
    chk("zx_count", 32'h3, d);
    zxp(3'b111, 1, 1);
    rdall;
    results;
  end
  initial
  begin
    #200000;
    fail_count++;
    results;
  end
endmodule

// >>> dv/eac_top_props.sv
// port checker for the energy input select and line-cycle block
// assumes binding into eac_top, one clock domain, sync reset
`timescale 1ns/1ns
module eac_top_chk
#(
  parameter DW = 12
)
(
  input wire          ref_clk_i,
  input wire          sys_rst_i,
  input wire [15:0]   reg_addr_i,
  input wire [31:0]   reg_wdata_i,
  input wire          reg_wr_i,
  input wire          reg_rd_i,
  input wire [31:0]   reg_rdata_o,
  input wire          sample_i,
  input wire [DW-1:0] vb_rms_i,
  input wire [DW-1:0] vac_rms_i,
  input wire          zx_a_i,
  input wire          zx_b_i,
  input wire          zx_c_i,
  input wire [1:0]    connection_select_o,
  input wire          line_period_o,
  input wire [DW-1:0] phase_b_voltage_rms_o
);
  // ============================================================
  // properties
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_cs_wr;
    reg_wr_i && reg_addr_i == 16'hE618;
  endsequence
  sequence s_lm_rd;
    reg_rd_i && reg_addr_i == 16'hE702;
  endsequence
  AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside read");
  AST_RSVD_ZERO: assert property
    (s_lm_rd |=> reg_rdata_o[31:7] == 25'h0)
    else $error("line mode reserved bits not zero");
  AST_UNMAPPED: assert property
    (reg_rd_i && reg_addr_i == 16'hE7FE |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_CS_SET: assert property
    (s_cs_wr |=> connection_select_o == $past(reg_wdata_i[1:0]))
    else $error("connection select not written");
  AST_CS_HOLD: assert property
    (!(reg_wr_i && reg_addr_i == 16'hE618) |=> $stable(connection_select_o))
    else $error("connection select changed");
  AST_LP_PULSE: assert property (line_period_o |=> !line_period_o)
    else $error("period pulse too long");
  AST_NO_ZX: assert property
    (!(zx_a_i || zx_b_i || zx_c_i) |=> !line_period_o)
    else $error("period without crossing");
  AST_BV_DELTA: assert property
    (sample_i && connection_select_o == 2'h1
     |=> phase_b_voltage_rms_o == $past(vac_rms_i))
    else $error("delta b rms not line rms");
  AST_BV_WYE: assert property
    (sample_i && connection_select_o == 2'h0
     |=> phase_b_voltage_rms_o == $past(vb_rms_i))
    else $error("wye b rms not phase rms");
  AST_BV_HOLD: assert property
    (!sample_i |=> $stable(phase_b_voltage_rms_o))
    else $error("b rms changed without sample");
endmodule

bind eac_top eac_top_chk #(.DW(DW)) u_chk (.ref_clk_i, .sys_rst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_i,
  .vb_rms_i, .vac_rms_i, .zx_a_i, .zx_b_i, .zx_c_i, .connection_select_o,
  .line_period_o, .phase_b_voltage_rms_o);

// >>> logic/eac_defines.vh
// register map, field positions and reset values of the energy
// accumulation input select and line-cycle control block
// assumes 16-bit register addresses and 32-bit register data
`ifndef EAC_DEFINES_VH
`define EAC_DEFINES_VH

// ============================================================
// register addresses
`define EAC_LCYC_MODE_ADDR     16'hE702
`define EAC_CONN_CFG_ADDR      16'hE618
`define EAC_LCYC_COUNT_ADDR    16'hE61C
`define EAC_ZX_STATE_ADDR      16'hE620
`define EAC_BV_RMS_ADDR        16'hE624
`define EAC_ENERGY_BASE_HI     12'hE40
`define EAC_ENERGY_NUM         4'hC

// ============================================================
// energy register indices
`define EAC_IDX_A_ACT          4'h0
`define EAC_IDX_A_VAR          4'h6
`define EAC_IDX_A_VA           4'h9

// ============================================================
// line-cycle mode fields
`define EAC_LM_ACTIVE_BIT      0
`define EAC_LM_REACTIVE_BIT    1
`define EAC_LM_APPARENT_BIT    2
`define EAC_LM_ZX_LSB          3
`define EAC_LM_ZX_MSB          5
`define EAC_LM_COR_BIT         6
`define EAC_LM_RSVD_BIT        7
`define EAC_LM_RESET           8'h78
`define EAC_LM_WR_MASK         8'h7F

// ============================================================
// connection select field and codes
`define EAC_CS_LSB             0
`define EAC_CS_MSB             1
`define EAC_CS_RESET           2'h0
`define EAC_CS_WYE3            2'h0
`define EAC_CS_DELTA3          2'h1
`define EAC_CS_WYE2            2'h2
`define EAC_CS_DELTA4          2'h3

// ============================================================
// line-cycle length in zero crossings
`define EAC_LCYC_COUNT_RESET   16'h0064

`endif

// >>> logic/eac_energy_acc.v
// one energy accumulator with regular and line-cycle modes
// assumes power is signed, valid while sample_i is high
`timescale 1ns/1ns
module eac_energy_acc
#(
  parameter PW = 26,
  parameter AW = 32
)
(
  input  wire                 ref_clk_i,
  input  wire                 sys_rst_i,
  input  wire                 sample_i,
  input  wire signed [PW-1:0] power_i,
  input  wire                 line_mode_i,
  input  wire                 period_end_i,
  input  wire                 clear_i,
  output reg  signed [AW-1:0] energy_o
);

  reg  signed [AW-1:0] period_sum;
  wire signed [AW-1:0] p_ext;

  assign p_ext = sample_i ? {{(AW-PW){power_i[PW-1]}}, power_i}
                          : {AW{1'b0}};

  // ============================================================
  // accumulation
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      energy_o   <= {AW{1'b0}};
      period_sum <= {AW{1'b0}};
    end
    else if (line_mode_i)
    begin
      if (period_end_i)
      begin
        energy_o   <= period_sum + p_ext;
        period_sum <= {AW{1'b0}};
      end
      else
      begin
        period_sum <= period_sum + p_ext;
        if (clear_i)
          energy_o <= {AW{1'b0}};
      end
    end
    else
    begin
      period_sum <= {AW{1'b0}};
      energy_o   <= (clear_i ? {AW{1'b0}} : energy_o) + p_ext;
    end
  end

endmodule

// >>> logic/eac_top.v
// energy accumulator input selection and line-cycle control
// assumes samples, rms values and zero crossings come from logic
// on ref_clk_i; registers reached over a plain strobe port
//
// Functional notes
// - phase a active energies use va times ia
// - phase c active energies use vc times ic
// - phase b voltage chosen by connection select
// - delta3 mode stores line a-c rms
// - bit 0 puts active energies in line-cycle
// - bit 1 puts reactive energies in line-cycle
// - bit 2 puts apparent energies in line-cycle
// - bits 3 to 5 select zero-crossing phases
// - several phases shorten line-cycle time proportionally
// - bit 6 makes energy reads clear registers
// - bit 7 reads zero, controls nothing
// - reactive energies use minus 90 degree currents
// - select codes wye3, delta3, wye2, delta4
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`include "eac_defines.vh"
module eac_top
#(
  parameter DW = 12,
  parameter AW = 32
)
(
  input  wire                 ref_clk_i,
  input  wire                 sys_rst_i,
  input  wire [15:0]          reg_addr_i,
  input  wire [31:0]          reg_wdata_i,
  input  wire                 reg_wr_i,
  input  wire                 reg_rd_i,
  output reg  [31:0]          reg_rdata_o,
  input  wire                 sample_i,
  input  wire signed [DW-1:0] va_i,
  input  wire signed [DW-1:0] vb_i,
  input  wire signed [DW-1:0] vc_i,
  input  wire signed [DW-1:0] ia_i,
  input  wire signed [DW-1:0] ib_i,
  input  wire signed [DW-1:0] ic_i,
  input  wire signed [DW-1:0] ia_q_i,
  input  wire signed [DW-1:0] ib_q_i,
  input  wire signed [DW-1:0] ic_q_i,
  input  wire signed [DW-1:0] va_f_i,
  input  wire signed [DW-1:0] vb_f_i,
  input  wire signed [DW-1:0] vc_f_i,
  input  wire signed [DW-1:0] ia_f_i,
  input  wire signed [DW-1:0] ib_f_i,
  input  wire signed [DW-1:0] ic_f_i,
  input  wire [DW-1:0]        va_rms_i,
  input  wire [DW-1:0]        vb_rms_i,
  input  wire [DW-1:0]        vc_rms_i,
  input  wire [DW-1:0]        vac_rms_i,
  input  wire [DW-1:0]        vsum_rms_i,
  input  wire [DW-1:0]        ia_rms_i,
  input  wire [DW-1:0]        ib_rms_i,
  input  wire [DW-1:0]        ic_rms_i,
  input  wire                 zx_a_i,
  input  wire                 zx_b_i,
  input  wire                 zx_c_i,
  output wire [1:0]           connection_select_o,
  output reg                  line_period_o,
  output reg  [DW-1:0]        phase_b_voltage_rms_o
);

  localparam PW = 2 * DW + 2;

  // ============================================================
  // registers
  reg  [7:0]           line_cycle_mode_ctrl;
  reg  [1:0]           connection_select;
  reg  [15:0]          line_cycle_count;
  reg  [15:0]          zx_cnt;
  wire                 active_line_cycle_en;
  wire                 reactive_line_cycle_en;
  wire                 apparent_line_cycle_en;
  wire [2:0]           zero_cross_phase_select;
  wire                 clear_on_read_en;

  assign active_line_cycle_en    = line_cycle_mode_ctrl[`EAC_LM_ACTIVE_BIT];
  assign reactive_line_cycle_en  =
    line_cycle_mode_ctrl[`EAC_LM_REACTIVE_BIT];
  assign apparent_line_cycle_en  =
    line_cycle_mode_ctrl[`EAC_LM_APPARENT_BIT];
  assign zero_cross_phase_select =
    line_cycle_mode_ctrl[`EAC_LM_ZX_MSB:`EAC_LM_ZX_LSB];
  assign clear_on_read_en        = line_cycle_mode_ctrl[`EAC_LM_COR_BIT];
  assign connection_select_o     = connection_select;

  // ============================================================
  // register writes
  reg  [7:0]           next_line_cycle_mode_ctrl;
  reg  [1:0]           next_connection_select;
  reg  [15:0]          next_line_cycle_count;

  always @*
  begin
    next_line_cycle_mode_ctrl = line_cycle_mode_ctrl;
    next_connection_select    = connection_select;
    next_line_cycle_count     = line_cycle_count;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `EAC_LCYC_MODE_ADDR:
          next_line_cycle_mode_ctrl =
            reg_wdata_i[7:0] & `EAC_LM_WR_MASK;
        `EAC_CONN_CFG_ADDR:
          next_connection_select =
            reg_wdata_i[`EAC_CS_MSB:`EAC_CS_LSB];
        `EAC_LCYC_COUNT_ADDR:
          next_line_cycle_count = reg_wdata_i[15:0];
        default:
          next_line_cycle_count = line_cycle_count;
      endcase
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      line_cycle_mode_ctrl <= `EAC_LM_RESET;
      connection_select    <= `EAC_CS_RESET;
      line_cycle_count     <= `EAC_LCYC_COUNT_RESET;
    end
    else
    begin
      line_cycle_mode_ctrl <= next_line_cycle_mode_ctrl;
      connection_select    <= next_connection_select;
      line_cycle_count     <= next_line_cycle_count;
    end
  end

  // ============================================================
  // zero-crossing count and line-cycle period
  wire [2:0]  zx_vec;
  wire [2:0]  zx_sel;
  wire [1:0]  zx_hits;
  wire [16:0] zx_next;
  wire        period_end;

  assign zx_vec = {zx_c_i, zx_b_i, zx_a_i};

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1)
    begin : g_zx
      assign zx_sel[ph] = zx_vec[ph] & zero_cross_phase_select[ph];
    end
  endgenerate

  assign zx_hits = {1'b0, zx_sel[0]} + {1'b0, zx_sel[1]}
                 + {1'b0, zx_sel[2]};
  assign zx_next = {1'b0, zx_cnt} + {15'h0000, zx_hits};
  assign period_end = (line_cycle_count != 16'h0000) &&
                      (zx_next >= {1'b0, line_cycle_count});

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      zx_cnt        <= 16'h0000;
      line_period_o <= 1'b0;
    end
    else
    begin
      line_period_o <= period_end;
      if (period_end)
        zx_cnt <= 16'h0000;
      else if (line_cycle_count != 16'h0000)
        zx_cnt <= zx_next[15:0];
    end
  end

  // ============================================================
  // operand extension
  wire signed [DW:0] va_x;
  wire signed [DW:0] vc_x;
  wire signed [DW:0] ia_x;
  wire signed [DW:0] ib_x;
  wire signed [DW:0] ic_x;
  wire signed [DW:0] iaq_x;
  wire signed [DW:0] ibq_x;
  wire signed [DW:0] icq_x;
  wire signed [DW:0] vaf_x;
  wire signed [DW:0] vcf_x;
  wire signed [DW:0] iaf_x;
  wire signed [DW:0] ibf_x;
  wire signed [DW:0] icf_x;
  wire signed [DW:0] vb_eff;
  wire signed [DW:0] vbf_eff;

  assign va_x  = {va_i[DW-1], va_i};
  assign vc_x  = {vc_i[DW-1], vc_i};
  assign ia_x  = {ia_i[DW-1], ia_i};
  assign ib_x  = {ib_i[DW-1], ib_i};
  assign ic_x  = {ic_i[DW-1], ic_i};
  assign iaq_x = {ia_q_i[DW-1], ia_q_i};
  assign ibq_x = {ib_q_i[DW-1], ib_q_i};
  assign icq_x = {ic_q_i[DW-1], ic_q_i};
  assign vaf_x = {va_f_i[DW-1], va_f_i};
  assign vcf_x = {vc_f_i[DW-1], vc_f_i};
  assign iaf_x = {ia_f_i[DW-1], ia_f_i};
  assign ibf_x = {ib_f_i[DW-1], ib_f_i};
  assign icf_x = {ic_f_i[DW-1], ic_f_i};

  eac_vb_select #(
    .DW       (DW)
  ) u_vb_sel (
    .sel_i    (connection_select),
    .va_i     (va_i),
    .vb_i     (vb_i),
    .vc_i     (vc_i),
    .vb_eff_o (vb_eff)
  );

  eac_vb_select #(
    .DW       (DW)
  ) u_vbf_sel (
    .sel_i    (connection_select),
    .va_i     (va_f_i),
    .vb_i     (vb_f_i),
    .vc_i     (vc_f_i),
    .vb_eff_o (vbf_eff)
  );

  // ============================================================
  // phase b rms selection
  reg  [DW-1:0]      vb_rms_sel;
  wire signed [DW:0] vbr_x;
  wire signed [DW:0] var_x;
  wire signed [DW:0] vcr_x;
  wire signed [DW:0] iar_x;
  wire signed [DW:0] ibr_x;
  wire signed [DW:0] icr_x;

  always @*
  begin
    case (connection_select)
      `EAC_CS_WYE3:   vb_rms_sel = vb_rms_i;
      `EAC_CS_DELTA3: vb_rms_sel = vac_rms_i;
      `EAC_CS_WYE2:   vb_rms_sel = vsum_rms_i;
      `EAC_CS_DELTA4: vb_rms_sel = va_rms_i;
      default:        vb_rms_sel = vb_rms_i;
    endcase
  end

  assign vbr_x = {1'b0, vb_rms_sel};
  assign var_x = {1'b0, va_rms_i};
  assign vcr_x = {1'b0, vc_rms_i};
  assign iar_x = {1'b0, ia_rms_i};
  assign ibr_x = {1'b0, ib_rms_i};
  assign icr_x = {1'b0, ic_rms_i};

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      phase_b_voltage_rms_o <= {DW{1'b0}};
    else if (sample_i)
      phase_b_voltage_rms_o <= vb_rms_sel;
  end

  // ============================================================
  // power products per energy register
  wire signed [PW-1:0] pw [0:11];

  assign pw[0]  = va_x * ia_x;
  assign pw[1]  = vb_eff * ib_x;
  assign pw[2]  = vc_x * ic_x;
  assign pw[3]  = vaf_x * iaf_x;
  assign pw[4]  = vbf_eff * ibf_x;
  assign pw[5]  = vcf_x * icf_x;
  assign pw[6]  = va_x * iaq_x;
  assign pw[7]  = vb_eff * ibq_x;
  assign pw[8]  = vc_x * icq_x;
  assign pw[9]  = var_x * iar_x;
  assign pw[10] = vbr_x * ibr_x;
  assign pw[11] = vcr_x * icr_x;

  // ============================================================
  // energy accumulators
  wire                 energy_hit;
  wire signed [AW-1:0] energy [0:11];

  assign energy_hit = (reg_addr_i[15:4] == `EAC_ENERGY_BASE_HI) &&
                      (reg_addr_i[3:0] < `EAC_ENERGY_NUM);

  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1)
    begin : g_acc
      wire mode;
      wire clr;
      assign mode = (g < `EAC_IDX_A_VAR) ? active_line_cycle_en :
                    (g < `EAC_IDX_A_VA)  ? reactive_line_cycle_en :
                                           apparent_line_cycle_en;
      assign clr = reg_rd_i && energy_hit && clear_on_read_en &&
                   (reg_addr_i[3:0] == g);
      eac_energy_acc #(
        .PW           (PW),
        .AW           (AW)
      ) u_acc (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .sample_i     (sample_i),
        .power_i      (pw[g]),
        .line_mode_i  (mode),
        .period_end_i (period_end),
        .clear_i      (clr),
        .energy_o     (energy[g])
      );
    end
  endgenerate

  // ============================================================
  // read port
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h00000000;
    if (energy_hit)
      next_rdata = energy[reg_addr_i[3:0]];
    else
    begin
      case (reg_addr_i)
        `EAC_LCYC_MODE_ADDR:
          next_rdata = {24'h000000, line_cycle_mode_ctrl};
        `EAC_CONN_CFG_ADDR:
          next_rdata = {30'h00000000, connection_select};
        `EAC_LCYC_COUNT_ADDR:
          next_rdata = {16'h0000, line_cycle_count};
        `EAC_ZX_STATE_ADDR:
          next_rdata = {16'h0000, zx_cnt};
        `EAC_BV_RMS_ADDR:
          next_rdata = {{(32-DW){1'b0}}, phase_b_voltage_rms_o};
        default:
          next_rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
    else
      reg_rdata_o <= 32'h00000000;
  end

endmodule

// >>> logic/eac_vb_select.v
// phase b voltage selector driven by the connection select code
// assumes samples are signed two's complement of width DW
`timescale 1ns/1ns
`include "eac_defines.vh"
module eac_vb_select
#(
  parameter DW = 12
)
(
  input  wire [1:0]          sel_i,
  input  wire signed [DW-1:0] va_i,
  input  wire signed [DW-1:0] vb_i,
  input  wire signed [DW-1:0] vc_i,
  output reg  signed [DW:0]   vb_eff_o
);

  wire signed [DW:0] va_x;
  wire signed [DW:0] vb_x;
  wire signed [DW:0] vc_x;

  assign va_x = {va_i[DW-1], va_i};
  assign vb_x = {vb_i[DW-1], vb_i};
  assign vc_x = {vc_i[DW-1], vc_i};

  // ============================================================
  // selection
  always @*
  begin
    case (sel_i)
      `EAC_CS_WYE3:   vb_eff_o = vb_x;
      `EAC_CS_DELTA3: vb_eff_o = va_x - vc_x;
      `EAC_CS_WYE2:   vb_eff_o = -va_x - vc_x;
      `EAC_CS_DELTA4: vb_eff_o = -va_x;
      default:        vb_eff_o = vb_x;
    endcase
  end

endmodule
